// ### verilog/sam_pkg.sv
// Purpose: Shared constants and types for the argument/transfer mode bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Offsets are byte addresses on an 8-bit Wishbone address
package sam_pkg;
   localparam logic [7:0]  SAM_OFS_ARG      = 8'h08;
   localparam logic [7:0]  SAM_OFS_MODE     = 8'h0c;
   localparam logic [7:0]  SAM_OFS_STAT     = 8'h10;
   localparam logic [31:0] SAM_ARG_RST      = 32'h0000_0000;
   localparam logic [15:0] SAM_MODE_RST     = 16'h0000;
   localparam int          SAM_MODE_RID_BIT = 8;
   localparam logic [31:0] SAM_R1_ERR_MASK  = 32'he6b8_0000;
   localparam logic [7:0]  SAM_R5_ERR_MASK  = 8'h8b;
   localparam int          SAM_R5_FLAG_LSB  = 8;

   typedef enum logic [1:0] {
      SAM_AUTO_NONE = 2'b00,
      SAM_AUTO_12   = 2'b01,
      SAM_AUTO_23   = 2'b10,
      SAM_AUTO_SEL  = 2'b11
   } sam_auto_t;

   typedef enum logic [1:0] {
      SAM_XT_SINGLE   = 2'b00,
      SAM_XT_INFINITE = 2'b01,
      SAM_XT_MULTI    = 2'b10,
      SAM_XT_STOP     = 2'b11
   } sam_xtype_t;

   typedef enum logic [2:0] {
      SAM_SEQ_IDLE   = 3'b000,
      SAM_SEQ_PRE23  = 3'b001,
      SAM_SEQ_MAIN   = 3'b010,
      SAM_SEQ_XFER   = 3'b011,
      SAM_SEQ_STOP12 = 3'b100
   } sam_seq_t;

   typedef struct packed {
      logic [6:0] rsvd;
      logic       resp_int_dis;
      logic       resp_chk_en;
      logic       resp_fmt_r5;
      logic       multi_blk;
      logic       dir_read;
      sam_auto_t  auto_cmd;
      logic       blk_cnt_en;
      logic       dma_en;
   } sam_xfer_mode_t;

   typedef struct packed {
      logic [24:0] rsvd;
      sam_seq_t    seq;
      sam_xtype_t  xtype;
      logic        auto_err;
      logic        resp_err;
   } sam_status_t;
endpackage

// ### verilog/sam_resp_check.sv
// Purpose: Registered R1/R5 response error flag decoder
// Assumes: valid_i is a one-cycle pulse with the response word
// Notes:   err_o follows valid_i by one cycle
`timescale 1ns/1ps
module sam_resp_check
   import sam_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        valid_i,
   input  wire logic        fmt_r5_i,
   input  wire logic [31:0] resp_i,
   output logic             err_o
);
   logic [7:0] r5_flags;
   logic       hit;

   assign r5_flags = resp_i[SAM_R5_FLAG_LSB +: 8];
   assign hit = fmt_r5_i ? |(r5_flags & SAM_R5_ERR_MASK)
                         : |(resp_i & SAM_R1_ERR_MASK);

   always_ff @(posedge clk_i) begin
      if (rst_i)
         err_o <= 1'b0;
      else
         err_o <= valid_i & hit;
   end

   AST_R1_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
      valid_i && !fmt_r5_i |=> err_o == $past(|{resp_i[31], resp_i[30],
         resp_i[29], resp_i[26], resp_i[25], resp_i[23], resp_i[21],
         resp_i[20], resp_i[19]}))
      else $error("R1 error flag decode wrong");
   AST_R5_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i)
      valid_i && fmt_r5_i |=> err_o == $past(|{resp_i[15], resp_i[11],
         resp_i[9], resp_i[8]}))
      else $error("R5 error flag decode wrong");
endmodule

// ### verilog/sam_auto_seq.sv
// Purpose: Sequencer for automatic CMD23 before and CMD12 after a command
// Assumes: resp_done_i and resp_err_i are aligned one-cycle pulses
// Notes:   All issue outputs are registered one-cycle pulses
`timescale 1ns/1ps
module sam_auto_seq
   import sam_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cmd_write_i,
   input  wire logic        use23_i,
   input  wire logic        use12_i,
   input  wire logic        resp_done_i,
   input  wire logic        resp_err_i,
   input  wire logic        last_block_i,
   input  wire logic [31:0] blk_cnt32_i,
   output logic             issue_main_o,
   output logic             issue_cmd23_o,
   output logic             issue_cmd12_o,
   output logic [31:0]      cmd23_arg_o,
   output logic             auto_err_o,
   output logic             auto_phase_o,
   output sam_seq_t         state_o
);
   sam_seq_t state;
   sam_seq_t next_state;
   logic     start;

   assign start        = (state == SAM_SEQ_IDLE) & cmd_write_i;
   assign auto_phase_o = (state == SAM_SEQ_PRE23) | (state == SAM_SEQ_STOP12);
   assign state_o      = state;

   always_comb begin
      next_state = state;
      case (state)
         SAM_SEQ_IDLE: begin
            if (cmd_write_i)
               next_state = use23_i ? SAM_SEQ_PRE23 : SAM_SEQ_MAIN;
         end
         SAM_SEQ_PRE23: begin
            if (resp_done_i)
               next_state = resp_err_i ? SAM_SEQ_IDLE : SAM_SEQ_MAIN;
         end
         SAM_SEQ_MAIN: begin
            if (resp_done_i)
               next_state = (use12_i && !resp_err_i) ? SAM_SEQ_XFER
                                                     : SAM_SEQ_IDLE;
         end
         SAM_SEQ_XFER: begin
            if (last_block_i)
               next_state = SAM_SEQ_STOP12;
         end
         SAM_SEQ_STOP12: begin
            if (resp_done_i)
               next_state = SAM_SEQ_IDLE;
         end
         default: next_state = SAM_SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         state <= SAM_SEQ_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         issue_cmd23_o <= 1'b0;
         issue_main_o  <= 1'b0;
         cmd23_arg_o   <= SAM_ARG_RST;
      end else begin
         issue_cmd23_o <= start & use23_i;
         issue_main_o  <= (start & ~use23_i) | ((state == SAM_SEQ_PRE23)
                          & resp_done_i & ~resp_err_i);
         if (start & use23_i)
            cmd23_arg_o <= blk_cnt32_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         issue_cmd12_o <= 1'b0;
         auto_err_o    <= 1'b0;
      end else begin
         issue_cmd12_o <= (state == SAM_SEQ_XFER) & last_block_i;
         auto_err_o    <= auto_phase_o & resp_done_i & resp_err_i;
      end
   end

   AST_CMD23_FIRST: assert property (@(posedge clk_i) disable iff (rst_i)
      start && use23_i |=> issue_cmd23_o && !issue_main_o
         && cmd23_arg_o == $past(blk_cnt32_i))
      else $error("CMD23 not issued ahead of command");
   AST_NO_MAIN_AFTER_ERR: assert property (@(posedge clk_i)
      disable iff (rst_i)
      state == SAM_SEQ_PRE23 && resp_done_i && resp_err_i
         |=> auto_err_o && !issue_main_o && state == SAM_SEQ_IDLE)
      else $error("Command issued after failed CMD23");
   AST_AUTO12_ISSUE: assert property (@(posedge clk_i) disable iff (rst_i)
      state == SAM_SEQ_XFER && last_block_i
         |=> issue_cmd12_o && state == SAM_SEQ_STOP12)
      else $error("Automatic CMD12 missing after last block");
endmodule

// ### verilog/sam_arg_xfer_mode.sv
// Purpose: Command argument and transfer mode register bank
// Assumes: All controller-side inputs are on clk_i; Wishbone classic slave
// Notes:   Every access is answered, unmapped ones with zero data
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module sam_arg_xfer_mode
   import sam_pkg::*;
#(
   parameter bit DMA_SUPPORT = 1'b1
)
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Controller status
   input  wire logic        data_line_inhibit_i,
   input  wire logic        ext_version_en_i,
   input  wire logic        card_count_cmd_support_i,
   input  wire logic [15:0] blk_cnt16_i,
   input  wire logic [31:0] blk_cnt32_i,
   input  wire logic        cmd_write_i,
   input  wire logic        block_done_i,
   input  wire logic        resp_done_i,
   input  wire logic        resp_err_i,
   input  wire logic [31:0] resp_i,
   // Controller controls
   output logic [31:0]      cmd_arg_o,
   output sam_xfer_mode_t   xfer_mode_o,
   output sam_xtype_t       xfer_type_o,
   output logic             xfer_read_o,
   output logic             dma_start_o,
   output logic             issue_main_o,
   output logic             issue_cmd23_o,
   output logic [31:0]      cmd23_arg_o,
   output logic             issue_cmd12_o,
   output logic             cmd_complete_o,
   output logic             resp_err_set_o,
   output logic             auto_cmd_err_o
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0]    cmd_arg;
   sam_xfer_mode_t xfer_mode;
   sam_xfer_mode_t next_mode;
   sam_status_t    status;
   logic [7:0]     adr_word;
   logic           wb_req;
   logic           wr_fire;
   logic [31:0]    rdata;
   logic           resp_err_st;
   logic           auto_err_st;
   logic           clr_resp_err;
   logic           clr_auto_err;
   logic           use23;
   logic           use12;
   logic           cnt_zero;
   logic           cnt_expired;
   logic           last_block;
   logic           chk_valid;
   logic           chk_fmt_r5;
   logic           chk_err;
   logic           resp_done_q;
   logic           resp_err_q;
   logic           phase_q;
   logic           auto_phase;
   logic           auto_err;
   sam_seq_t       seq_state;

   ////////////////////////////////////////////////////////////////////////
   // Wishbone slave: ack one cycle after the request, writes on the ack
   assign wb_req   = wb_cyc_i & wb_stb_i;
   assign wr_fire  = wb_req & wb_we_i & wb_ack_o;
   assign adr_word = {wb_adr_i[7:2], 2'b00};

   always_ff @(posedge clk_i) begin
      if (rst_i)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= wb_req & ~wb_ack_o;
   end

   always_comb begin
      rdata = '0;
      case (adr_word)
         SAM_OFS_ARG:  rdata = cmd_arg;
         SAM_OFS_MODE: rdata = {16'h0000, xfer_mode};
         SAM_OFS_STAT: rdata = status;
         default:      rdata = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         wb_dat_o <= '0;
      else if (wb_req & ~wb_ack_o & ~wb_we_i)
         wb_dat_o <= rdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Argument register
   // argument byte lanes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_arg <= SAM_ARG_RST;
      end else if (wr_fire && adr_word == SAM_OFS_ARG) begin
         for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i])
               cmd_arg[8*i +: 8] <= wb_dat_i[8*i +: 8];
         end
      end
   end

   assign cmd_arg_o = cmd_arg;

   ////////////////////////////////////////////////////////////////////////
   // Transfer mode register
   always_comb begin
      next_mode = xfer_mode;
      if (wb_sel_i[0])
         next_mode[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1])
         next_mode.resp_int_dis = wb_dat_i[SAM_MODE_RID_BIT];
      next_mode.rsvd = '0;
      if (!DMA_SUPPORT)
         next_mode.dma_en = 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         xfer_mode <= SAM_MODE_RST;
      else if (wr_fire && adr_word == SAM_OFS_MODE && !data_line_inhibit_i)
         xfer_mode <= next_mode;
   end

   assign xfer_mode_o = xfer_mode;

   always_ff @(posedge clk_i) begin
      if (rst_i)
         xfer_read_o <= 1'b0;
      else
         xfer_read_o <= xfer_mode.dir_read;
   end

   ////////////////////////////////////////////////////////////////////////
   // Transfer type from mode bits and selected block count
   assign cnt_zero = (!ext_version_en_i || blk_cnt16_i != '0)
                   ? (blk_cnt16_i == '0) : (blk_cnt32_i == '0);

   always_ff @(posedge clk_i) begin
      if (rst_i)
         xfer_type_o <= SAM_XT_SINGLE;
      else if (!xfer_mode.multi_blk)
         xfer_type_o <= SAM_XT_SINGLE;
      else if (!xfer_mode.blk_cnt_en)
         xfer_type_o <= SAM_XT_INFINITE;
      else if (cnt_zero)
         xfer_type_o <= SAM_XT_STOP;
      else
         xfer_type_o <= SAM_XT_MULTI;
   end

   ////////////////////////////////////////////////////////////////////////
   // Automatic command selection and count expiry
   // mode choice
   assign use23 = (xfer_mode.auto_cmd == SAM_AUTO_23)
                | (xfer_mode.auto_cmd == SAM_AUTO_SEL
                   &  card_count_cmd_support_i);
   assign use12 = (xfer_mode.auto_cmd == SAM_AUTO_12)
                | (xfer_mode.auto_cmd == SAM_AUTO_SEL
                   & ~card_count_cmd_support_i);

   assign cnt_expired = (blk_cnt16_i == '0)
                      | (ext_version_en_i & (blk_cnt32_i == '0));

   assign last_block = block_done_i & cnt_expired & xfer_mode.multi_blk
                     & xfer_mode.blk_cnt_en;

   ////////////////////////////////////////////////////////////////////////
   // Response checking; auto commands are always checked as R1
   assign chk_valid  = resp_done_i & (auto_phase | xfer_mode.resp_chk_en);
   assign chk_fmt_r5 = ~auto_phase & xfer_mode.resp_fmt_r5;

   sam_resp_check u_check (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .valid_i  (chk_valid),
      .fmt_r5_i (chk_fmt_r5),
      .resp_i   (resp_i),
      .err_o    (chk_err)
   );

   // Delay keeps the done strobe aligned with the registered check
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resp_done_q <= 1'b0;
         resp_err_q  <= 1'b0;
         phase_q     <= 1'b0;
      end else begin
         resp_done_q <= resp_done_i;
         resp_err_q  <= resp_err_i;
         phase_q     <= auto_phase;
      end
   end

   sam_auto_seq u_seq (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .cmd_write_i   (cmd_write_i),
      .use23_i       (use23),
      .use12_i       (use12),
      .resp_done_i   (resp_done_q),
      .resp_err_i    (resp_err_q | chk_err),
      .last_block_i  (last_block),
      .blk_cnt32_i   (blk_cnt32_i),
      .issue_main_o  (issue_main_o),
      .issue_cmd23_o (issue_cmd23_o),
      .issue_cmd12_o (issue_cmd12_o),
      .cmd23_arg_o   (cmd23_arg_o),
      .auto_err_o    (auto_err),
      .auto_phase_o  (auto_phase),
      .state_o       (seq_state)
   );

   ////////////////////////////////////////////////////////////////////////
   // Events toward the interrupt logic of the controller
   // suppress and flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_complete_o <= 1'b0;
         resp_err_set_o <= 1'b0;
         auto_cmd_err_o <= 1'b0;
      end else begin
         cmd_complete_o <= resp_done_q & ~phase_q & ~xfer_mode.resp_int_dis;
         resp_err_set_o <= chk_err & ~phase_q;
         auto_cmd_err_o <= auto_err;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         dma_start_o <= 1'b0;
      else
         dma_start_o <= cmd_write_i & xfer_mode.dma_en;
   end

   ////////////////////////////////////////////////////////////////////////
   // Status register: sticky, write one to clear, a new event wins
   assign clr_resp_err = wr_fire & (adr_word == SAM_OFS_STAT)
                       & wb_sel_i[0] & wb_dat_i[0];
   assign clr_auto_err = wr_fire & (adr_word == SAM_OFS_STAT)
                       & wb_sel_i[0] & wb_dat_i[1];

   always_ff @(posedge clk_i) begin
      if (rst_i)
         resp_err_st <= 1'b0;
      else
         resp_err_st <= (resp_err_st & ~clr_resp_err) | (chk_err & ~phase_q);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i)
         auto_err_st <= 1'b0;
      else
         auto_err_st <= (auto_err_st & ~clr_auto_err) | auto_err;
   end

   always_comb begin
      status          = '0;
      status.seq      = seq_state;
      status.xtype    = xfer_type_o;
      status.auto_err = auto_err_st;
      status.resp_err = resp_err_st;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_ARG_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_fire && adr_word == SAM_OFS_ARG && wb_sel_i == 4'hf
         |=> cmd_arg_o == $past(wb_dat_i))
      else $error("Argument write not applied");

   AST_MODE_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_req && wb_we_i && adr_word == SAM_OFS_MODE && data_line_inhibit_i
         |=> $stable(xfer_mode_o))
      else $error("Transfer mode changed while inhibited");

   AST_CC_SUPPRESS: assert property (@(posedge clk_i) disable iff (rst_i)
      resp_done_i && !auto_phase
         |=> ##1 cmd_complete_o == !$past(xfer_mode_o.resp_int_dis))
      else $error("Command complete not gated by disable bit");

   AST_RESP_ERR: assert property (@(posedge clk_i) disable iff (rst_i)
      chk_err && !phase_q |=> resp_err_set_o && status.resp_err)
      else $error("Response error not reported");

   AST_SINGLE: assert property (@(posedge clk_i) disable iff (rst_i)
      !xfer_mode_o.multi_blk |=> xfer_type_o == SAM_XT_SINGLE)
      else $error("Single block type wrong");

   AST_INFINITE: assert property (@(posedge clk_i) disable iff (rst_i)
      xfer_mode_o.multi_blk && !xfer_mode_o.blk_cnt_en
         |=> xfer_type_o == SAM_XT_INFINITE)
      else $error("Infinite type wrong");

   AST_AUTO_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_state == SAM_SEQ_IDLE && cmd_write_i
         && xfer_mode_o.auto_cmd == SAM_AUTO_SEL
         |=> issue_cmd23_o == $past(card_count_cmd_support_i))
      else $error("Automatic selection picked the wrong command");

   AST_DMA_START: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_write_i |=> dma_start_o == $past(xfer_mode_o.dma_en))
      else $error("DMA start does not follow command write");

   AST_STICKY_SET_WINS: assert property (@(posedge clk_i)
      disable iff (rst_i)
      auto_err && clr_auto_err |=> status.auto_err)
      else $error("Auto error lost against a clear");
endmodule

// ### dv/sam_card_model.sv
// Purpose: Card side model answering each issued command
// Assumes: cmd_i is a one-cycle issue pulse from the bank
// Notes:   Response latency is wait_i plus two cycles
`timescale 1ns/1ps
module sam_card_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cmd_i,
   input  wire logic [3:0]  wait_i,
   input  wire logic        bad_i,
   input  wire logic [31:0] word_i,
   output logic             done_o,
   output logic             err_o,
   output logic [31:0]      resp_o
);
   logic [4:0] cnt;
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      // Stale word is not held, so a late sample shows garbage
      resp_o <= ~resp_o;
      if (rst_i) begin
         cnt <= 5'h00;
         resp_o <= 32'h0;
      end else if (cmd_i) begin
         cnt <= {1'b0, wait_i} + 5'h01;
      end else if (cnt == 5'h01) begin
         cnt <= 5'h00;
         done_o <= 1'b1;
         err_o <= bad_i;
         resp_o <= word_i;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
   end
endmodule

// ### dv/sam_arg_xfer_mode_tb_top.sv
// Purpose: Self-checking bench for the argument/transfer mode bank
// Assumes: Card model answers every issued command
// Notes:   Pulse outputs are counted and compared per command run
`timescale 1ns/1ps
module sam_arg_xfer_mode_tb_top;
   import sam_pkg::*;
   logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, inh = 0, ext = 0;
   logic sup = 0, cmdw = 0, bdone = 0, bad = 0, ack, rdone, rerr, rdir;
   logic [7:0]  adr = 8'h00;
   logic [15:0] b16 = 16'h0;
   logic [31:0] dat = 32'h0, b32 = 32'h0, rw = 32'h0, q, rd, rsp, arg, a23;
   logic [3:0]  dly = 4'h0;
   logic [6:0]  p;
   sam_xfer_mode_t xm;
   sam_xtype_t     xt;
   int n[7], base[7], error_cnt = 0, comparisons = 0, cyc_cnt = 0;
   int r1b[9] = '{31, 30, 29, 26, 25, 23, 21, 20, 19};
   int r5b[4] = '{7, 3, 1, 0};
   sam_arg_xfer_mode dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
      .data_line_inhibit_i(inh), .ext_version_en_i(ext),
      .card_count_cmd_support_i(sup), .blk_cnt16_i(b16), .blk_cnt32_i(b32),
      .cmd_write_i(cmdw), .block_done_i(bdone), .resp_done_i(rdone),
      .resp_err_i(rerr), .resp_i(rsp), .cmd_arg_o(arg), .xfer_mode_o(xm),
      .xfer_type_o(xt), .xfer_read_o(rdir), .dma_start_o(p[6]),
      .issue_main_o(p[0]), .issue_cmd23_o(p[1]), .cmd23_arg_o(a23),
      .issue_cmd12_o(p[2]), .cmd_complete_o(p[3]), .resp_err_set_o(p[4]),
      .auto_cmd_err_o(p[5]));
   sam_card_model card (.clk_i(clk_i), .rst_i(rst_i),
      .cmd_i(p[0] | p[1] | p[2]), .wait_i(dly), .bad_i(bad), .word_i(rw),
      .done_o(rdone), .err_o(rerr), .resp_o(rsp));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt > 20000) begin
         error_cnt++;
         finish_test();
      end
      if (!rst_i) for (int i = 0; i < 7; i++) n[i] += p[i];
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string s, input logic [31:0] e, g);
      comparisons++;
      if (e !== g) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
      int k = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1);
      r = rd;
      chk("wb_ack_wait", 32'h0000_0002, k);
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic logic [1:0] xtype(logic [15:0] m, logic [15:0] c,
                                        logic e, logic [31:0] c32);
      if (!m[5]) return 2'b00;
      if (!m[1]) return 2'b01;
      if (e && c == 16'h0) return (c32 != 32'h0) ? 2'b10 : 2'b11;
      return (c != 16'h0) ? 2'b10 : 2'b11;
   endfunction
   task automatic seq(input logic [15:0] m, input logic s, b,
                      input logic [31:0] w, input logic [6:0] e);
      logic [6:0] g;
      sup <= s;
      bad <= b;
      rw <= w;
      b16 <= ext ? 16'h5 : 16'h0;
      b32 <= ext ? 32'h0 : $urandom;
      dly <= 4'($urandom_range(12));
      wb(1'b1, SAM_OFS_MODE, {16'h0, m}, q);
      base = n;
      cmdw <= 1'b1;
      @(posedge clk_i);
      cmdw <= 1'b0;
      repeat (40) @(posedge clk_i);
      bdone <= 1'b1;
      @(posedge clk_i);
      bdone <= 1'b0;
      repeat (40) @(posedge clk_i);
      for (int i = 0; i < 7; i++) g[i] = (n[i] != base[i]);
      chk("pulses", {25'h0, e}, {25'h0, g});
      if (e[1]) chk("cmd23_arg", b32, a23);
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] m;
      logic [31:0] v;
      void'($urandom(32'ha0b8));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      repeat (4) begin
         v = $urandom;
         wb(1'b1, SAM_OFS_ARG, v, q);
         wb(1'b0, SAM_OFS_ARG, 32'h0, q);
         chk("arg", v, q);
         chk("arg_o", v, arg);
      end
      wb(1'b1, SAM_OFS_MODE, 32'hffff_ffff, q);
      wb(1'b0, SAM_OFS_MODE, 32'h0, q);
      chk("mode", 32'h01ff, q);
      chk("mode_o", 32'h01ff, {16'h0, xm});
      inh <= 1'b1;
      wb(1'b1, SAM_OFS_MODE, 32'h0, q);
      wb(1'b0, SAM_OFS_MODE, 32'h0, q);
      chk("mode_lock", 32'h01ff, q);
      inh <= 1'b0;
      wb(1'b0, 8'h20, 32'h0, q);
      chk("unmapped", 32'h0, q);
      for (int i = 0; i < 8; i++) begin
         m = {10'h0, i[2], 1'($urandom), 2'b00, i[1], 1'b0};
         b16 <= i[0] ? 16'h0 : 16'($urandom_range(65535, 1));
         b32 <= i[0] ? 32'($urandom_range(1)) : $urandom;
         ext <= 1'($urandom);
         wb(1'b1, SAM_OFS_MODE, {16'h0, m}, q);
         @(posedge clk_i);
         chk("type", {30'h0, xtype(m, b16, ext, b32)},
             {30'h0, xt});
         chk("dir", {31'h0, m[4]}, {31'h0, rdir});
      end
      ext <= 1'b0;
      @(posedge clk_i);
      seq(16'h0000, 0, 0, $urandom, 7'b0001001);
      seq(16'h0001, 0, 0, 32'h0, 7'b1001001);
      seq(16'h0100, 0, 0, 32'h0, 7'b0000001);
      foreach (r1b[i])
         seq(16'h0180, 0, 0, 32'h1 << r1b[i], 7'b0010001);
      seq(16'h0180, 0, 0, 32'h0800_0000, 7'b0000001);
      foreach (r5b[i])
         seq(16'h01c0, 0, 0, 32'h100 << r5b[i], 7'b0010001);
      seq(16'h01c0, 0, 0, 32'h8000_0000, 7'b0000001);
      seq(16'h0028, 1, 0, 32'h0, 7'b0001011);
      seq(16'h0028, 1, 1, 32'h0, 7'b0100010);
      seq(16'h0026, 0, 0, 32'h0, 7'b0001101);
      // Count held nonzero, only the 32-bit count expires
      ext <= 1'b1;
      @(posedge clk_i);
      seq(16'h0026, 0, 0, 32'h0, 7'b0001101);
      ext <= 1'b0;
      @(posedge clk_i);
      seq(16'h002e, 1, 0, 32'h0, 7'b0001011);
      seq(16'h002e, 0, 0, 32'h0, 7'b0001101);
      // Infinite run never leaves the transfer state, so it goes last
      seq(16'h0024, 0, 0, 32'h0, 7'b0001001);
      wb(1'b0, SAM_OFS_STAT, 32'h0, q);
      chk("status", 32'h0000_0037, q);
      wb(1'b1, SAM_OFS_STAT, 32'h0000_0003, q);
      wb(1'b0, SAM_OFS_STAT, 32'h0, q);
      chk("status_clr", 32'h0000_0034, q);
      finish_test();
   end
endmodule
